// [core/ebc_pkg.sv]
package ebc_pkg;
    // register byte offsets
    localparam logic [7:0] EBC_STATUS_LO_OFF  = 8'h00;
    localparam logic [7:0] EBC_STATUS_HI_OFF  = 8'h04;
    localparam logic [7:0] EBC_CAP_OFF        = 8'h08;
    localparam logic [7:0] EBC_FEATURE_OFF    = 8'h0c;
    localparam logic [7:0] EBC_EXTRA_LO_OFF   = 8'h10;
    localparam logic [7:0] EBC_EXTRA_HI_OFF   = 8'h14;
    localparam logic [7:0] EBC_LOC_LO_OFF     = 8'h18;
    localparam logic [7:0] EBC_LOC_HI_OFF     = 8'h1c;
    localparam logic [7:0] EBC_CTL_OFF        = 8'h20;
    // bit positions within the high status word (status bits 63..32), the capability word and the feature word
    localparam int EBC_LIVE_BIT    = 31;
    localparam int EBC_OVER_BIT    = 30;
    localparam int EBC_UNCORR_BIT  = 29;
    localparam int EBC_EN_BIT      = 28;
    localparam int EBC_EXTRA_BIT   = 27;
    localparam int EBC_LOC_BIT     = 26;
    localparam int EBC_CORRUPT_BIT = 25;
    localparam int EBC_SIG_BIT     = 24;
    localparam int EBC_ACTION_BIT  = 23;
    localparam int EBC_CAP_RECOV_BIT = 24;
    localparam int EBC_FEAT_MCA_BIT  = 14;
    localparam int EBC_FEAT_MCE_BIT  = 7;
    localparam logic [31:0] EBC_CTL_RESET = 32'h0000_0000;
    localparam logic [1:0]  EBC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  EBC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        EBC_CLS_CE      = 3'b000,
        EBC_CLS_LATENT  = 3'b001,
        EBC_CLS_OPTREC  = 3'b010,
        EBC_CLS_REQREC  = 3'b011,
        EBC_CLS_CORRUPT = 3'b100
    } ebc_class_t;

    typedef struct packed {
        logic        valid;
        ebc_class_t  cls;
        logic        consumed;
        logic        extra_ok;
        logic        loc_ok;
        logic [15:0] code;
        logic [63:0] extra;
        logic [63:0] loc;
    } ebc_report_t;

    typedef struct packed {
        logic        live;
        logic        over;
        logic        uncorr;
        logic        en;
        logic        extra_ok;
        logic        loc_ok;
        logic        corrupt;
        logic        sig;
        logic        action;
        logic [15:0] code;
        logic [63:0] extra;
        logic [63:0] loc;
    } ebc_bank_t;
endpackage : ebc_pkg

// [core/ebc_bank.sv]
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - latent class: uncorrected, unsignaled, corrected path
// RULE2 - optional recovery: signaled, logging on, no action
// RULE3 - required recovery: signaled, logging on, action
// RULE4 - uncorrected entries live, enabled, first not overflowed
// RULE5 - recoverable classes only with recovery capability
// RULE6 - recoverable error replaces held corrected error
// RULE7 - context corrupt beats recoverable, both orders
// RULE8 - second recoverable keeps first error contents
// RULE9 - corrected error never replaces recoverable error
// RULE10 - overflow flag on every second error
// RULE11 - signaled and action flags sticky, ORed unless the held error is context corrupt
// RULE12 - info flags only with valid data
// RULE13 - required recovery raised at consumption point
// RULE14 - software policy on missing info flags
// RULE15 - software resets only on action/corrupt overflow
// RULE16 - software zeroes status after power-up
// RULE17 - feature bits 14 and 7 reported
// RULE18 - software enables exceptions, vector 18
// RULE19 - software writes ones to logging controls
// RULE20 - only software or reset clears sticky flags
// RULE21 - same-cycle reports resolved as first, second
module ebc_bank
    import ebc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        recovery_support_cap,
    input  wire ebc_report_t rpt_a,
    input  wire ebc_report_t rpt_b,
    output logic             machine_check_exc,
    output logic             corrected_error_signal,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ebc_bank_t   bank_q, bank_d;
    logic [31:0] ctl_q, ctl_d;
    logic        mce_q, mce_d;
    logic        cmc_q, cmc_d;
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    function automatic ebc_class_t eff_class(input ebc_report_t r, input logic cap);
        ebc_class_t c;
        c = r.cls;
        // RULE5 recoverable needs capability
        if (!cap && (c == EBC_CLS_LATENT || c == EBC_CLS_OPTREC || c == EBC_CLS_REQREC))
            c = EBC_CLS_CORRUPT;
        // RULE13 raise at consumption
        if (c == EBC_CLS_REQREC && !r.consumed)
            c = EBC_CLS_OPTREC;
        return c;
    endfunction : eff_class

    function automatic logic is_rec(input ebc_class_t c);
        return c == EBC_CLS_LATENT || c == EBC_CLS_OPTREC || c == EBC_CLS_REQREC;
    endfunction : is_rec

    function automatic ebc_bank_t fresh(input ebc_report_t r, input ebc_class_t c);
        ebc_bank_t b;
        b = '0;
        b.live     = 1'b1;
        b.uncorr   = (c != EBC_CLS_CE);
        // RULE4 live and enabled
        b.en       = (c != EBC_CLS_CE);
        b.corrupt  = (c == EBC_CLS_CORRUPT);
        // RULE1 RULE2 RULE3 class flags
        b.sig      = (c == EBC_CLS_OPTREC || c == EBC_CLS_REQREC);
        b.action   = (c == EBC_CLS_REQREC);
        // RULE12 info only when valid
        b.extra_ok = r.extra_ok;
        b.loc_ok   = r.loc_ok;
        b.code     = r.code;
        b.extra    = r.extra_ok ? r.extra : 64'h0;
        b.loc      = r.loc_ok ? r.loc : 64'h0;
        return b;
    endfunction : fresh

    function automatic ebc_bank_t apply(input ebc_bank_t h, input ebc_report_t r, input logic cap);
        ebc_class_t c;
        ebc_bank_t  n;
        logic       h_rec;
        c = eff_class(r, cap);
        n = fresh(r, c);
        h_rec = h.uncorr && !h.corrupt;
        if (!r.valid)
            return h;
        if (!h.live)
            return n;
        // RULE10 overflow on second
        n.over = 1'b1;
        h.over = 1'b1;
        if (!h.uncorr) begin
            // RULE6 recoverable replaces corrected
            if (c != EBC_CLS_CE)
                return n;
            return h;
        end
        // RULE7 corrupt wins both orders
        if (h_rec && c == EBC_CLS_CORRUPT) begin
            n.sig    = h.sig | n.sig;
            n.action = h.action | n.action;
            return n;
        end
        // RULE8 RULE9 first kept
        // RULE11 sticky ORed flags
        if (h_rec && is_rec(c)) begin
            h.sig    = h.sig | n.sig;
            h.action = h.action | n.action;
        end
        return h;
    endfunction : apply

    function automatic ebc_bank_t no_sticky(input ebc_bank_t b);
        ebc_bank_t n;
        n        = b;
        n.sig    = 1'b0;
        n.action = 1'b0;
        return n;
    endfunction : no_sticky

    function automatic logic [31:0] hi_word(input ebc_bank_t b);
        logic [31:0] w;
        w                  = 32'h0;
        w[EBC_LIVE_BIT]    = b.live;
        w[EBC_OVER_BIT]    = b.over;
        w[EBC_UNCORR_BIT]  = b.uncorr;
        w[EBC_EN_BIT]      = b.en;
        w[EBC_EXTRA_BIT]   = b.extra_ok;
        w[EBC_LOC_BIT]     = b.loc_ok;
        w[EBC_CORRUPT_BIT] = b.corrupt;
        w[EBC_SIG_BIT]     = b.sig;
        w[EBC_ACTION_BIT]  = b.action;
        return w;
    endfunction : hi_word

    function automatic ebc_bank_t load_hi(input ebc_bank_t b, input logic [31:0] w);
        ebc_bank_t n;
        n          = b;
        n.live     = w[EBC_LIVE_BIT];
        n.over     = w[EBC_OVER_BIT];
        n.uncorr   = w[EBC_UNCORR_BIT];
        n.en       = w[EBC_EN_BIT];
        n.extra_ok = w[EBC_EXTRA_BIT];
        n.loc_ok   = w[EBC_LOC_BIT];
        n.corrupt  = w[EBC_CORRUPT_BIT];
        n.sig      = w[EBC_SIG_BIT];
        n.action   = w[EBC_ACTION_BIT];
        return n;
    endfunction : load_hi

    function automatic logic [31:0] feature_word();
        logic [31:0] w;
        w                   = 32'h0;
        w[EBC_FEAT_MCA_BIT] = 1'b1;
        w[EBC_FEAT_MCE_BIT] = 1'b1;
        return w;
    endfunction : feature_word

    // bank update
    always_comb begin
        bank_d = bank_q;
        // RULE21 a first, b second
        bank_d = apply(bank_d, rpt_a, recovery_support_cap);
        bank_d = apply(bank_d, rpt_b, recovery_support_cap);
        mce_d = 1'b0;
        cmc_d = 1'b0;
        if (ctl_q != 32'h0) begin
            mce_d = (rpt_a.valid && eff_class(rpt_a, recovery_support_cap) inside
                     {EBC_CLS_OPTREC, EBC_CLS_REQREC, EBC_CLS_CORRUPT})
                  || (rpt_b.valid && eff_class(rpt_b, recovery_support_cap) inside
                     {EBC_CLS_OPTREC, EBC_CLS_REQREC, EBC_CLS_CORRUPT});
            cmc_d = (rpt_a.valid && eff_class(rpt_a, recovery_support_cap) inside {EBC_CLS_CE, EBC_CLS_LATENT})
                  || (rpt_b.valid && eff_class(rpt_b, recovery_support_cap) inside {EBC_CLS_CE, EBC_CLS_LATENT});
        end
        if (ctl_q == 32'h0) begin
            bank_d = bank_q;
        end
        ctl_d = ctl_q;
        // write side
        aw_d = aw_q;
        w_d  = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = EBC_RESP_OKAY;
            // RULE20 software clear only
            unique case (awa_q)
                EBC_STATUS_LO_OFF: if (ws_q != 4'h0) bank_d.code = wd_q[15:0];
                EBC_STATUS_HI_OFF: if (ws_q != 4'h0) bank_d = load_hi(bank_d, wd_q);
                EBC_EXTRA_LO_OFF: bank_d.extra[31:0]  = wd_q;
                EBC_EXTRA_HI_OFF: bank_d.extra[63:32] = wd_q;
                EBC_LOC_LO_OFF:   bank_d.loc[31:0]    = wd_q;
                EBC_LOC_HI_OFF:   bank_d.loc[63:32]   = wd_q;
                EBC_CTL_OFF:      ctl_d = wd_q;
                EBC_CAP_OFF, EBC_FEATURE_OFF: br_d = EBC_RESP_OKAY;
                default:          br_d = EBC_RESP_SLVERR;
            endcase
        end
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        // read side
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = EBC_RESP_OKAY;
            unique case (s_axi_araddr)
                EBC_STATUS_LO_OFF: rd_d = {16'h0, bank_q.code};
                EBC_STATUS_HI_OFF: rd_d = hi_word(bank_q);
                EBC_CAP_OFF:      rd_d = {7'h0, recovery_support_cap, 24'h0};
                // RULE17 feature bits
                EBC_FEATURE_OFF:  rd_d = feature_word();
                EBC_EXTRA_LO_OFF: rd_d = bank_q.extra[31:0];
                EBC_EXTRA_HI_OFF: rd_d = bank_q.extra[63:32];
                EBC_LOC_LO_OFF:   rd_d = bank_q.loc[31:0];
                EBC_LOC_HI_OFF:   rd_d = bank_q.loc[63:32];
                EBC_CTL_OFF:      rd_d = ctl_q;
                default: begin
                    rd_d = 32'h0;
                    rr_d = EBC_RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready  = !w_q && !bv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign machine_check_exc      = mce_q;
    assign corrected_error_signal = cmc_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            // RULE20 reset clears only sticky flags
            bank_q <= no_sticky(bank_d);
            ctl_q  <= EBC_CTL_RESET;
            mce_q  <= 1'b0;
            cmc_q  <= 1'b0;
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bv_q   <= 1'b0;
            rv_q   <= 1'b0;
            awa_q  <= 8'h00;
            wd_q   <= 32'h0;
            ws_q   <= 4'h0;
            br_q   <= EBC_RESP_OKAY;
            rd_q   <= 32'h0;
            rr_q   <= EBC_RESP_OKAY;
        end else begin
            bank_q <= bank_d;
            ctl_q  <= ctl_d;
            mce_q  <= mce_d;
            cmc_q  <= cmc_d;
            aw_q   <= aw_d;
            w_q    <= w_d;
            bv_q   <= bv_d;
            rv_q   <= rv_d;
            awa_q  <= awa_d;
            wd_q   <= wd_d;
            ws_q   <= ws_d;
            br_q   <= br_d;
            rd_q   <= rd_d;
            rr_q   <= rr_d;
        end
    end
endmodule : ebc_bank

// [verification/ebc_bank_sva.sv]
`timescale 1ns/1ps
module ebc_bank_sva
    import ebc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        recovery_support_cap,
    input wire ebc_report_t rpt_a,
    input wire ebc_report_t rpt_b,
    input wire logic        machine_check_exc,
    input wire logic        corrected_error_signal,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire logic ce_in  = rpt_a.valid && rpt_a.cls <= EBC_CLS_LATENT || rpt_b.valid && rpt_b.cls <= EBC_CLS_LATENT;
    wire logic exc_in = rpt_a.valid && rpt_a.cls != EBC_CLS_CE || rpt_b.valid && rpt_b.cls != EBC_CLS_CE;
    wire logic lat_a  = rpt_a.valid && !rpt_b.valid && recovery_support_cap && rpt_a.cls == EBC_CLS_LATENT;
    wire logic rec_a  = rpt_a.valid && !rpt_b.valid && recovery_support_cap
                        && rpt_a.cls inside {EBC_CLS_OPTREC, EBC_CLS_REQREC};
    property p_ce_cause;
        corrected_error_signal |-> $past(ce_in);
    endproperty
    a_ce_cause: assert property (p_ce_cause) else $error("corrected signal without cause");
    property p_exc_cause;
        machine_check_exc |-> $past(exc_in);
    endproperty
    a_exc_cause: assert property (p_exc_cause) else $error("exception without cause");
    property p_latent_no_exc;
        lat_a |=> !machine_check_exc;
    endproperty
    a_latent_no_exc: assert property (p_latent_no_exc) else $error("latent error raised exception");
    property p_rec_no_ce;
        rec_a |=> !corrected_error_signal;
    endproperty
    a_rec_no_ce: assert property (p_rec_no_ce) else $error("recovery error took corrected path");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    property p_b_clear;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 !s_axi_bvalid;
    endproperty
    a_b_clear: assert property (p_b_clear) else $error("write response repeated");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read data late");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while data pending");
    property p_one_path;
        machine_check_exc && !$past(rpt_a.valid && rpt_b.valid) |-> !corrected_error_signal;
    endproperty
    a_one_path: assert property (p_one_path) else $error("both signal paths raised");
    c_exc: cover property (machine_check_exc);
    c_ce: cover property (corrected_error_signal);
    c_dual: cover property (rpt_a.valid && rpt_b.valid);
endmodule : ebc_bank_sva

bind ebc_bank ebc_bank_sva u_sva (.core_clk, .reset, .recovery_support_cap, .rpt_a, .rpt_b, .machine_check_exc,
    .corrected_error_signal, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// [verification/ebc_bank_tb.sv]
`timescale 1ns/1ps
module ebc_bank_tb
    import ebc_pkg::*;
;
    logic        core_clk, reset, recovery_support_cap, machine_check_exc, corrected_error_signal;
    ebc_report_t rpt_a, rpt_b;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, hi, lo;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ta, tw, bv, exc_s, ce_s;
    int          mismatches, checks;
    // class, consumed, extra, exc, ce, flags, mask
    localparam logic [24:0] ST [6] = '{{3'h1, 4'h9, 9'h160, 9'h1ff}, {3'h2, 4'he, 9'h172, 9'h1ff},
        {3'h3, 4'ha, 9'h163, 9'h1ff}, {3'h3, 4'h2, 9'h162, 9'h1ff}, {3'h4, 4'ha, 9'h164, 9'h1e4},
        {3'h0, 4'h9, 9'h100, 9'h140}};
    // first, second, second kept, flags, mask
    localparam logic [24:0] PT [8] = '{{3'h0, 3'h2, 1'h1, 9'h1e2, 9'h1ff}, {3'h2, 3'h0, 1'h0, 9'h1e2, 9'h1ff},
        {3'h1, 3'h3, 1'h0, 9'h1e3, 9'h1ff}, {3'h3, 3'h1, 1'h0, 9'h1e3, 9'h1ff}, {3'h2, 3'h4, 1'h1, 9'h1e4, 9'h1e4},
        {3'h4, 3'h2, 1'h0, 9'h1e4, 9'h1e4}, {3'h0, 3'h0, 1'h0, 9'h180, 9'h1c0}, {3'h2, 3'h2, 1'h0, 9'h1e2, 9'h1ff}};
    ebc_bank DUT (.core_clk, .reset, .recovery_support_cap, .rpt_a, .rpt_b, .machine_check_exc,
        .corrected_error_signal, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bv = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!bv);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            bv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!bv);
    endtask : rd
    function automatic ebc_report_t mk(input logic [2:0] c, input logic u, input logic x, input logic [15:0] k);
        ebc_report_t r;
        r = '0;
        r.valid = 1'h1;
        r.cls = ebc_class_t'(c);
        r.consumed = u;
        r.extra_ok = x;
        r.extra = 64'h1;
        r.code = k;
        return r;
    endfunction : mk
    task automatic send(input ebc_report_t a, input ebc_report_t b);
        rpt_a <= a;
        rpt_b <= b;
        @(posedge core_clk);
        rpt_a <= '0;
        rpt_b <= '0;
        @(negedge core_clk);
        exc_s = machine_check_exc;
        ce_s = corrected_error_signal;
        @(posedge core_clk);
    endtask : send
    task automatic flags(input logic [8:0] e, input logic [8:0] m);
        rd(EBC_STATUS_HI_OFF, hi, rr);
        chk("status_flags", 32'(e & m), 32'(hi[31:23] & m));
    endtask : flags
    task automatic clr();
        wr(EBC_STATUS_HI_OFF, 32'h0);
        wr(EBC_STATUS_LO_OFF, 32'h0);
    endtask : clr
    initial begin
        #2_000_000;
        mismatches++;
        close_out();
    end
    initial begin
        reset <= 1'h1;
        recovery_support_cap <= 1'h1;
        rpt_a <= '0;
        rpt_b <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= '0;
        s_axi_wstrb <= 4'hf;
        s_axi_bready <= 1'h1;
        s_axi_rready <= 1'h1;
        repeat (16) @(posedge core_clk);
        reset <= 1'h0;
        send(mk(3'h2, 1'h1, 1'h0, 16'h0011), '0);
        chk("exc_disabled", 32'h0, 32'(exc_s));
        wr(EBC_CTL_OFF, 32'hffff_ffff);
        rd(EBC_FEATURE_OFF, lo, rr);
        chk("feature", 32'h0000_4080, lo);
        rd(EBC_CAP_OFF, lo, rr);
        chk("cap", 32'h1, 32'(lo[EBC_CAP_RECOV_BIT]));
        wr(8'h40, 32'h0);
        chk("unmapped_wr", 32'(EBC_RESP_SLVERR), 32'(br));
        rd(8'h40, lo, rr);
        chk("unmapped_rd", {30'h0, EBC_RESP_SLVERR}, {lo[29:0], rr});
        foreach (ST[i]) begin
            clr();
            send(mk(ST[i][24:22], ST[i][21], ST[i][20], 16'h0011), '0);
            chk("exc", 32'(ST[i][19]), 32'(exc_s));
            chk("ce", 32'(ST[i][18]), 32'(ce_s));
            flags(ST[i][17:9], ST[i][8:0]);
        end
        for (int m = 0; m < 2; m++) begin
            foreach (PT[i]) begin
                clr();
                if (m == 0) begin
                    send(mk(PT[i][24:22], 1'h1, 1'h0, 16'h0011), '0);
                    send(mk(PT[i][21:19], 1'h1, 1'h0, 16'h0022), '0);
                end else begin
                    send(mk(PT[i][24:22], 1'h1, 1'h0, 16'h0011), mk(PT[i][21:19], 1'h1, 1'h0, 16'h0022));
                end
                flags(PT[i][17:9], PT[i][8:0]);
                rd(EBC_STATUS_LO_OFF, lo, rr);
                chk("code", PT[i][18] ? 32'h22 : 32'h11, {16'h0, lo[15:0]});
            end
        end
        recovery_support_cap <= 1'h0;
        for (int c = 1; c < 4; c++) begin
            clr();
            send(mk(3'(c), 1'h1, 1'h0, 16'h0011), '0);
            flags(9'h164, 9'h1e7);
        end
        recovery_support_cap <= 1'h1;
        clr();
        send(mk(3'h3, 1'h1, 1'h0, 16'h0011), '0);
        reset <= 1'h1;
        @(posedge core_clk);
        reset <= 1'h0;
        flags(9'h000, 9'h003);
        close_out();
    end
endmodule : ebc_bank_tb
